// ==== pkg/tec_regs.svh ====
// register offsets, field positions, reset values and tlp codes of the transaction error checker
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

`define TEC_OFS_CTRL          8'h00
`define TEC_OFS_DEVCTL        8'h04
`define TEC_OFS_VC0CTL        8'h08
`define TEC_OFS_DBGSTS        8'h0C
`define TEC_OFS_LASTEV        8'h10

`define TEC_CTRL_ECRC_BIT     0
`define TEC_CTRL_UPSTREAM_BIT 1
`define TEC_CTRL_RST          2'h0
`define TEC_DEVCTL_MPS_LSB    5
`define TEC_DEVCTL_MPS_RST    3'h0
`define TEC_VC0_MAP_LSB       0
`define TEC_VC0_MAP_RST       8'h01
`define TEC_DBG_RXOVF_BIT     0
`define TEC_LASTEV_SEV_LSB    0
`define TEC_LASTEV_LOG_BIT    2
`define TEC_LASTEV_CAUSE_LSB  4

`define TEC_TYP_MEM           5'h00
`define TEC_TYP_MEMLK         5'h01
`define TEC_TYP_IO            5'h02
`define TEC_TYP_CFG0          5'h04
`define TEC_TYP_CFG1          5'h05
`define TEC_TYP_CPL           5'h0A
`define TEC_TYP_CPLLK         5'h0B
`define TEC_TYP_TCFG          5'h1B

`define TEC_RT_TO_RC          3'h0
`define TEC_RT_BCAST          3'h3
`define TEC_RT_GATHER         3'h5

`define TEC_MSG_UNLOCK        8'h00
`define TEC_MSG_PM_NAK        8'h14
`define TEC_MSG_PM_PME        8'h18
`define TEC_MSG_PME_OFF       8'h19
`define TEC_MSG_PME_TO_ACK    8'h1B
`define TEC_MSG_INTX_HI       5'h04
`define TEC_MSG_ERR_COR       8'h30
`define TEC_MSG_ERR_NF        8'h31
`define TEC_MSG_ERR_F         8'h33
`define TEC_MSG_SET_PWR       8'h50

`define TEC_MPS_BASE_DW       13'h0020
`define TEC_LEN_MAX_DW        11'h400
`define TEC_HDR_ECRC_DW       12'h004

`endif

// ==== pkg/tec_pkg.sv ====
// types shared by the transaction error checker
package tec_pkg;

    typedef enum logic [1:0] {
        TEC_SEV_NONE     = 2'b00,
        TEC_SEV_COR      = 2'b01,
        TEC_SEV_NONFATAL = 2'b10,
        TEC_SEV_FATAL    = 2'b11
    } tec_sev_t;

    typedef enum logic [3:0] {
        TEC_CAUSE_NONE     = 4'h0,
        TEC_CAUSE_MALF_IN  = 4'h1,
        TEC_CAUSE_MALF_EG  = 4'h2,
        TEC_CAUSE_OVERFLOW = 4'h3,
        TEC_CAUSE_ECRC     = 4'h4,
        TEC_CAUSE_POISON   = 4'h5,
        TEC_CAUSE_UNSUPP   = 4'h6,
        TEC_CAUSE_UNEXP    = 4'h7
    } tec_cause_t;

    typedef struct packed {
        logic [1:0]   fmt;
        logic [4:0]   typ;
        logic [2:0]   tc;
        logic [1:0]   attr;
        logic         td;
        logic         ep;
        logic [9:0]   len;
        logic [3:0]   last_be;
        logic [7:0]   msg_code;
        logic [10:0]  payload_dw;
        logic [11:0]  total_dw;
        logic         ecrc_bad;
        logic         is_dest;
        logic         unsupported;
        logic         unexp_cpl;
        logic [127:0] hdr;
    } tec_tlp_t;

    typedef struct packed {
        logic         valid;
        tec_sev_t     sev;
        logic         log_hdr;
        tec_cause_t   cause;
        logic [127:0] hdr;
    } tec_evt_t;

endpackage : tec_pkg

// ==== rtl/tec_tlp_err_chk.sv ====
// transaction-layer error classifier and malformed tlp checker for one switch port, ahb-lite registers
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "tec_regs.svh"

module tec_tlp_err_chk
    import tec_pkg::*;
(
    input  wire logic        hclk,       // core clock
    input  wire logic        hresetn,    // async reset, active low
    input  wire logic        hsel,       // slave select
    input  wire logic [31:0] haddr,      // byte address
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write when high
    input  wire logic [2:0]  hsize,      // word only
    input  wire logic [31:0] hwdata,     // write data
    input  wire logic        hready,     // bus ready
    output logic             hreadyout,  // slave ready
    output logic             hresp,      // always okay
    output logic [31:0]      hrdata,     // read data
    input  wire logic        rx_valid,   // received tlp strobe
    input  wire tec_tlp_t    rx_tlp,     // received tlp descriptor
    input  wire logic        rx_ovf,     // receiver overflow pulse
    input  wire logic        eg_valid,   // egress tlp strobe
    input  wire logic [2:0]  eg_tc,      // egress traffic class
    input  wire logic [127:0] eg_hdr,    // egress header
    output tec_evt_t         err_evt     // error event
);

    // decode helpers
    function automatic logic fmt_type_legal(input logic [1:0] fmt, input logic [4:0] typ);
        logic ok;
        ok = 1'b0;
        if (typ[4:3] == 2'b10) begin
            ok = fmt[0] && (typ[2:0] <= `TEC_RT_GATHER);
        end else begin
            case (typ)
                `TEC_TYP_MEM:                  ok = 1'b1;
                `TEC_TYP_MEMLK:                ok = !fmt[1];
                `TEC_TYP_IO, `TEC_TYP_CFG0,
                `TEC_TYP_CFG1, `TEC_TYP_CPL,
                `TEC_TYP_CPLLK:                ok = !fmt[0];
                `TEC_TYP_TCFG:                 ok = fmt[0];
                default:                       ok = 1'b0;
            endcase
        end
        return ok;
    endfunction : fmt_type_legal

    function automatic logic tc_to_vc0(input logic [7:0] map, input logic [2:0] tc);
        return map[tc];
    endfunction : tc_to_vc0

    // registers
    // control reset word split per bit so each flop takes exactly one bit of it
    localparam logic [1:0] ctrl_rst_val = `TEC_CTRL_RST;

    logic        ecrc_en_r;
    logic        upstream_r;
    logic [2:0]  mps_r;
    logic [7:0]  vc0_map_r;
    logic        rx_overflow_flag_r;
    tec_sev_t    last_sev_r;
    logic        last_log_r;
    tec_cause_t  last_cause_r;

    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    logic        hreadyout_r;
    logic        hresp_r;
    logic [31:0] hrdata_r;
    tec_evt_t    evt_r;

    logic        addr_phase;
    logic        wr_commit;
    logic        dbg_clr;

    // a read gets one wait state so it always sees a write that ended just before it
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_commit  = wr_pend_r;
    assign dbg_clr    = wr_commit && (addr_r == `TEC_OFS_DBGSTS) && hwdata[`TEC_DBG_RXOVF_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            rd_pend_r <= addr_phase && !hwrite;
        end
    end

    // the offset is kept for the data phase and only moves when a new transfer is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_r <= 8'h00;
        end else if (addr_phase) begin
            addr_r <= haddr[7:0];
        end
    end

    // one wait state per read; writes never stall the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_r <= 1'b1;
        end else begin
            hreadyout_r <= !(addr_phase && !hwrite);
        end
    end

    // every access answers okay, unmapped offsets included; kept in a flop like the other bus outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_r <= 1'b0;
        end else begin
            hresp_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ecrc_en_r  <= ctrl_rst_val[`TEC_CTRL_ECRC_BIT];
            upstream_r <= ctrl_rst_val[`TEC_CTRL_UPSTREAM_BIT];
            mps_r      <= `TEC_DEVCTL_MPS_RST;
            vc0_map_r  <= `TEC_VC0_MAP_RST;
        end else if (wr_commit) begin
            case (addr_r)
                `TEC_OFS_CTRL: begin
                    ecrc_en_r  <= hwdata[`TEC_CTRL_ECRC_BIT];
                    upstream_r <= hwdata[`TEC_CTRL_UPSTREAM_BIT];
                end
                `TEC_OFS_DEVCTL: mps_r     <= hwdata[`TEC_DEVCTL_MPS_LSB +: 3];
                `TEC_OFS_VC0CTL: vc0_map_r <= hwdata[`TEC_VC0_MAP_LSB +: 8];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata_r <= 32'h0000_0000;
            case (addr_r)
                `TEC_OFS_CTRL: begin
                    hrdata_r[`TEC_CTRL_ECRC_BIT]     <= ecrc_en_r;
                    hrdata_r[`TEC_CTRL_UPSTREAM_BIT] <= upstream_r;
                end
                `TEC_OFS_DEVCTL: hrdata_r[`TEC_DEVCTL_MPS_LSB +: 3] <= mps_r;
                `TEC_OFS_VC0CTL: hrdata_r[`TEC_VC0_MAP_LSB +: 8]    <= vc0_map_r;
                `TEC_OFS_DBGSTS: hrdata_r[`TEC_DBG_RXOVF_BIT]       <= rx_overflow_flag_r;
                `TEC_OFS_LASTEV: begin
                    hrdata_r[`TEC_LASTEV_SEV_LSB +: 2]   <= last_sev_r;
                    hrdata_r[`TEC_LASTEV_LOG_BIT]        <= last_log_r;
                    hrdata_r[`TEC_LASTEV_CAUSE_LSB +: 4] <= last_cause_r;
                end
                default: ;
            endcase
        end
    end

    // overflow flag: write one to clear, a new overflow in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_overflow_flag_r <= 1'b0;
        end else if (rx_ovf) begin
            rx_overflow_flag_r <= 1'b1;
        end else if (dbg_clr) begin
            rx_overflow_flag_r <= 1'b0;
        end
    end

    // ingress malformed checks
    logic [10:0] len_dw;
    logic [12:0] mps_dw;
    logic [11:0] exp_total;
    logic        is_msg;
    logic [2:0]  route;
    logic        is_intx;
    logic        tc0_msg;
    logic        malf_in;
    logic        non_posted;

    always_comb begin
        len_dw    = (rx_tlp.len == 10'h000) ? `TEC_LEN_MAX_DW : {1'b0, rx_tlp.len};
        mps_dw    = `TEC_MPS_BASE_DW << mps_r;
        exp_total = `TEC_HDR_ECRC_DW + {11'h000, rx_tlp.fmt[0]} + (rx_tlp.fmt[1] ? {1'b0, len_dw} : 12'h000);
        is_msg    = (rx_tlp.typ[4:3] == 2'b10);
        route     = rx_tlp.typ[2:0];
        is_intx   = is_msg && (rx_tlp.msg_code[7:3] == `TEC_MSG_INTX_HI);
        tc0_msg   = is_msg && (is_intx ||
                    rx_tlp.msg_code == `TEC_MSG_PM_NAK  || rx_tlp.msg_code == `TEC_MSG_PM_PME ||
                    rx_tlp.msg_code == `TEC_MSG_PME_OFF || rx_tlp.msg_code == `TEC_MSG_PME_TO_ACK ||
                    rx_tlp.msg_code == `TEC_MSG_ERR_COR || rx_tlp.msg_code == `TEC_MSG_ERR_NF ||
                    rx_tlp.msg_code == `TEC_MSG_ERR_F   || rx_tlp.msg_code == `TEC_MSG_UNLOCK ||
                    rx_tlp.msg_code == `TEC_MSG_SET_PWR);
        malf_in = 1'b0;
        if (!fmt_type_legal(rx_tlp.fmt, rx_tlp.typ)) begin
            malf_in = 1'b1;
        end
        if (rx_tlp.fmt[1] && ({2'b00, len_dw} > mps_dw)) begin
            malf_in = 1'b1;
        end
        if (rx_tlp.fmt[1] && (rx_tlp.payload_dw != len_dw)) begin
            malf_in = 1'b1;
        end
        if (rx_tlp.td && (rx_tlp.total_dw != exp_total)) begin
            malf_in = 1'b1;
        end
        if ((rx_tlp.typ == `TEC_TYP_IO || rx_tlp.typ == `TEC_TYP_CFG0 || rx_tlp.typ == `TEC_TYP_CFG1) &&
            (rx_tlp.len != 10'h001 || rx_tlp.tc != 3'h0 || rx_tlp.attr != 2'h0 || rx_tlp.last_be != 4'h0)) begin
            malf_in = 1'b1;
        end
        if (tc0_msg && rx_tlp.tc != 3'h0) begin
            malf_in = 1'b1;
        end
        if (is_msg && route == `TEC_RT_TO_RC && upstream_r) begin
            malf_in = 1'b1;
        end
        if (is_msg && route == `TEC_RT_BCAST && !upstream_r) begin
            malf_in = 1'b1;
        end
        if (is_msg && route == `TEC_RT_GATHER && (upstream_r || rx_tlp.msg_code != `TEC_MSG_PME_TO_ACK)) begin
            malf_in = 1'b1;
        end
        if (is_intx && upstream_r) begin
            malf_in = 1'b1;
        end
        if (rx_tlp.typ == `TEC_TYP_TCFG && !upstream_r) begin
            malf_in = 1'b1;
        end
        if (!tc_to_vc0(vc0_map_r, rx_tlp.tc)) begin
            malf_in = 1'b1;
        end
        // posted means memory writes and messages; everything else waits for a completion
        non_posted = !is_msg && !(rx_tlp.typ == `TEC_TYP_MEM && rx_tlp.fmt[1]);
    end

    // classification
    // only one event leaves per cycle; lower-priority errors of the same tlp are dropped
    // flow control errors are never checked and completions are never awaited, so no
    // input exists for them
    tec_evt_t evt_nxt;

    // hdr follows the descriptor while no event is raised; only valid qualifies it
    always_comb begin
        evt_nxt = '0;
        evt_nxt.hdr = rx_tlp.hdr;
        if (rx_valid && malf_in) begin
            evt_nxt.valid   = 1'b1;
            evt_nxt.sev     = TEC_SEV_FATAL;
            evt_nxt.log_hdr = 1'b1;
            evt_nxt.cause   = TEC_CAUSE_MALF_IN;
        end else if (rx_ovf) begin
            evt_nxt.valid   = 1'b1;
            evt_nxt.sev     = TEC_SEV_FATAL;
            evt_nxt.log_hdr = 1'b0;
            evt_nxt.cause   = TEC_CAUSE_OVERFLOW;
            evt_nxt.hdr     = 128'h0;
        end else if (rx_valid && ecrc_en_r && rx_tlp.td && rx_tlp.ecrc_bad) begin
            evt_nxt.valid   = 1'b1;
            evt_nxt.sev     = rx_tlp.is_dest ? TEC_SEV_NONFATAL : TEC_SEV_COR;
            evt_nxt.log_hdr = 1'b1;
            evt_nxt.cause   = TEC_CAUSE_ECRC;
        end else if (rx_valid && rx_tlp.ep) begin
            evt_nxt.valid   = 1'b1;
            evt_nxt.sev     = rx_tlp.is_dest ? TEC_SEV_NONFATAL : TEC_SEV_COR;
            evt_nxt.log_hdr = 1'b1;
            evt_nxt.cause   = TEC_CAUSE_POISON;
        end else if (rx_valid && rx_tlp.unsupported) begin
            evt_nxt.valid   = 1'b1;
            evt_nxt.sev     = non_posted ? TEC_SEV_COR : TEC_SEV_NONFATAL;
            evt_nxt.log_hdr = 1'b1;
            evt_nxt.cause   = TEC_CAUSE_UNSUPP;
        end else if (rx_valid && rx_tlp.unexp_cpl) begin
            // every unexpected completion falls in the advisory list
            evt_nxt.valid   = 1'b1;
            evt_nxt.sev     = TEC_SEV_COR;
            evt_nxt.log_hdr = 1'b1;
            evt_nxt.cause   = TEC_CAUSE_UNEXP;
        end else if (eg_valid && !tc_to_vc0(vc0_map_r, eg_tc)) begin
            evt_nxt.valid   = 1'b1;
            evt_nxt.sev     = TEC_SEV_FATAL;
            evt_nxt.log_hdr = 1'b1;
            evt_nxt.cause   = TEC_CAUSE_MALF_EG;
            evt_nxt.hdr     = eg_hdr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_r <= '0;
        end else begin
            evt_r <= evt_nxt;
        end
    end

    // software sees the latest event here until the next one replaces it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_sev_r   <= TEC_SEV_NONE;
            last_log_r   <= 1'b0;
            last_cause_r <= TEC_CAUSE_NONE;
        end else if (evt_nxt.valid) begin
            last_sev_r   <= evt_nxt.sev;
            last_log_r   <= evt_nxt.log_hdr;
            last_cause_r <= evt_nxt.cause;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp     = hresp_r;
    assign hrdata    = hrdata_r;
    assign err_evt   = evt_r;

endmodule : tec_tlp_err_chk

`default_nettype wire

// ==== verification/tec_lnk_partner.sv ====
// link partner model: launches received tlps into the checker one cycle after a request
`timescale 1ns/100ps
`default_nettype none
module tec_lnk_partner
    import tec_pkg::*;
(
    input  wire logic     hclk,     // core clock
    input  wire logic     hresetn,  // async reset, active low
    input  wire logic     go,       // send tlp_in next cycle
    input  wire tec_tlp_t tlp_in,   // tlp to send
    output logic          rx_valid, // tlp strobe
    output tec_tlp_t      rx_tlp    // tlp descriptor
);
    // between tlps the descriptor toggles so no stale field can pass for a live one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_valid <= 1'b0;
            rx_tlp   <= '0;
        end else begin
            rx_valid <= go;
            rx_tlp   <= go ? tlp_in : ~rx_tlp;
        end
    end
endmodule : tec_lnk_partner
`default_nettype wire

// ==== verification/tec_chk_props.sv ====
// concurrent checks on the error checker ports
`timescale 1ns/100ps
`default_nettype none
module tec_chk_props
    import tec_pkg::*;
(
    input wire logic         hclk,      // core clock
    input wire logic         hresetn,   // async reset, active low
    input wire logic         hsel,      // slave select
    input wire logic [31:0]  haddr,     // byte address
    input wire logic [1:0]   htrans,    // transfer type
    input wire logic         hwrite,    // write when high
    input wire logic [2:0]   hsize,     // transfer size
    input wire logic [31:0]  hwdata,    // write data
    input wire logic         hready,    // bus ready
    input wire logic         hreadyout, // slave ready
    input wire logic         hresp,     // response
    input wire logic [31:0]  hrdata,    // read data
    input wire logic         rx_valid,  // received tlp strobe
    input wire tec_tlp_t     rx_tlp,    // received tlp
    input wire logic         rx_ovf,    // receiver overflow
    input wire logic         eg_valid,  // egress strobe
    input wire logic [2:0]   eg_tc,     // egress traffic class
    input wire logic [127:0] eg_hdr,    // egress header
    input wire tec_evt_t     err_evt    // error event
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_evt_has_cause: assert property (err_evt.valid |-> $past(rx_valid || rx_ovf || eg_valid))
        else $error("event without a strobe");
    a_ovf_fatal: assert property (rx_ovf && !rx_valid |=> err_evt.valid && err_evt.cause == TEC_CAUSE_OVERFLOW
        && err_evt.sev == TEC_SEV_FATAL) else $error("overflow not fatal");
    a_ovf_nolog: assert property (err_evt.valid && err_evt.cause == TEC_CAUSE_OVERFLOW |-> !err_evt.log_hdr
        && err_evt.hdr == 128'h0) else $error("overflow header logged");
    a_malf_fatal: assert property (err_evt.valid && err_evt.cause inside {TEC_CAUSE_MALF_IN,
        TEC_CAUSE_MALF_EG} |-> err_evt.sev == TEC_SEV_FATAL && err_evt.log_hdr) else $error("malformed not fatal");
    a_poison_sev: assert property (err_evt.valid && err_evt.cause == TEC_CAUSE_POISON |-> err_evt.log_hdr
        && err_evt.sev == ($past(rx_tlp.is_dest) ? TEC_SEV_NONFATAL : TEC_SEV_COR)) else $error("poison severity");
    a_ecrc_sev: assert property (err_evt.valid && err_evt.cause == TEC_CAUSE_ECRC |->
        $past(rx_tlp.td) && err_evt.sev == ($past(rx_tlp.is_dest) ? TEC_SEV_NONFATAL : TEC_SEV_COR))
        else $error("ecrc severity");
    a_ur_sev: assert property (err_evt.valid && err_evt.cause == TEC_CAUSE_UNSUPP |-> err_evt.sev ==
        (($past(rx_tlp.typ[4:3]) != 2'b10 && !($past(rx_tlp.typ) == 5'h00 && $past(rx_tlp.fmt[1])))
        ? TEC_SEV_COR : TEC_SEV_NONFATAL)) else $error("unsupported severity");
    a_unexp_cor: assert property (err_evt.valid && err_evt.cause == TEC_CAUSE_UNEXP |->
        err_evt.sev == TEC_SEV_COR) else $error("unexpected completion severity");
    a_hdr_capture: assert property (err_evt.valid && err_evt.cause == TEC_CAUSE_MALF_EG |->
        err_evt.hdr == $past(eg_hdr)) else $error("egress header not captured");
    a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
endmodule : tec_chk_props
bind tec_tlp_err_chk tec_chk_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid), .rx_tlp(rx_tlp), .rx_ovf(rx_ovf), .eg_valid(eg_valid),
    .eg_tc(eg_tc), .eg_hdr(eg_hdr), .err_evt(err_evt));
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the transaction error checker
`timescale 1ns/100ps
`default_nettype none
`include "tec_regs.svh"
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin miscompares++; \
    $display("BAD %s exp %0h got %0h", nm, e, a); end end
module tb_top
    import tec_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_ovf = 0, eg_valid = 0, go = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, seed = 32'h2B90;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2, eg_tc = '0;
    logic [127:0] eg_hdr = '0;
    logic hreadyout, hresp, rx_valid;
    tec_tlp_t cur = '0, rx_tlp, t;
    tec_evt_t err_evt;
    int miscompares = 0, check_count = 0;
    always #10 hclk = ~hclk;
    tec_lnk_partner i_partner (.hclk(hclk), .hresetn(hresetn), .go(go), .tlp_in(cur), .rx_valid(rx_valid),
        .rx_tlp(rx_tlp));
    tec_tlp_err_chk i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid), .rx_tlp(rx_tlp), .rx_ovf(rx_ovf),
        .eg_valid(eg_valid), .eg_tc(eg_tc), .eg_hdr(eg_hdr), .err_evt(err_evt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic tec_tlp_t mk(input logic [1:0] f, input logic [4:0] ty, input logic [9:0] ln,
                                    input logic [2:0] tc, input logic [7:0] code);
        tec_tlp_t r;
        r = '0;
        r.fmt = f; r.typ = ty; r.len = ln; r.tc = tc; r.msg_code = code;
        r.payload_dw = f[1] ? {1'b0, ln} : 11'h0;
        r.total_dw = 12'd3 + f[0] + r.payload_dw;
        r.hdr = {4{seed}};
        return r;
    endfunction : mk
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // the master waits on hreadyout as long as it takes; only the watchdog ends a hang
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk); hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr
    task automatic chk_evt(input tec_cause_t c, input tec_sev_t s, input logic [127:0] h);
        `CHK("valid", c != TEC_CAUSE_NONE, err_evt.valid)
        if (c != TEC_CAUSE_NONE) begin
            `CHK("cause", c, err_evt.cause)
            `CHK("sev", s, err_evt.sev)
            `CHK("log", c != TEC_CAUSE_OVERFLOW, err_evt.log_hdr)
            `CHK("hdr", c == TEC_CAUSE_OVERFLOW ? 128'h0 : h, err_evt.hdr)
        end
    endtask : chk_evt
    task automatic tx(input tec_tlp_t p, input tec_cause_t c, input tec_sev_t s);
        seed = lfsr(seed);
        @(posedge hclk); go <= 1'b1; cur <= p;
        @(posedge hclk); go <= 1'b0;
        @(posedge hclk); #1;
        chk_evt(c, s, p.hdr);
    endtask : tx
    task automatic eg(input logic [2:0] tc, input tec_cause_t c);
        seed = lfsr(seed);
        @(posedge hclk); eg_valid <= 1'b1; eg_tc <= tc; eg_hdr <= {seed, ~seed, seed, ~seed};
        @(posedge hclk); eg_valid <= 1'b0; #1;
        chk_evt(c, TEC_SEV_FATAL, {seed, ~seed, seed, ~seed});
    endtask : eg
    localparam tec_cause_t MI = TEC_CAUSE_MALF_IN;
    localparam tec_cause_t NO = TEC_CAUSE_NONE;
    localparam tec_sev_t FA = TEC_SEV_FATAL;
    localparam tec_sev_t NF = TEC_SEV_NONFATAL;
    localparam tec_sev_t CO = TEC_SEV_COR;
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `TEC_OFS_CTRL, 0, rd); `CHK("ctrl", 32'h0, rd)
        ahb(1'b0, `TEC_OFS_DEVCTL, 0, rd); `CHK("devctl", 32'h0, rd)
        ahb(1'b0, `TEC_OFS_VC0CTL, 0, rd); `CHK("vc0ctl", 32'h1, rd)
        ahb(1'b0, `TEC_OFS_DBGSTS, 0, rd); `CHK("dbgsts", 32'h0, rd)
        ahb(1'b0, 8'h20, 0, rd); `CHK("unmapped", 32'h0, rd)
        $display("test registers done");
        t = mk(2'b00, 5'h00, 1, 0, 0); t.td = 1; t.ecrc_bad = 1; t.is_dest = 1; t.total_dw = 4; tx(t, NO, NF);
        wr(`TEC_OFS_CTRL, 32'h1);
        tx(t, TEC_CAUSE_ECRC, NF);
        t.is_dest = 0; tx(t, TEC_CAUSE_ECRC, CO);
        t = mk(2'b00, 5'h00, 1, 0, 0); t.ep = 1; t.is_dest = 1; tx(t, TEC_CAUSE_POISON, NF);
        t.is_dest = 0; tx(t, TEC_CAUSE_POISON, CO);
        t = mk(2'b00, 5'h00, 1, 0, 0); t.unsupported = 1; tx(t, TEC_CAUSE_UNSUPP, CO);
        t = mk(2'b10, 5'h00, 1, 0, 0); t.unsupported = 1; tx(t, TEC_CAUSE_UNSUPP, NF);
        t = mk(2'b00, `TEC_TYP_CPL, 1, 0, 0); t.unexp_cpl = 1; tx(t, TEC_CAUSE_UNEXP, CO);
        $display("test classification done");
        tx(mk(2'b00, 5'h03, 1, 0, 0), MI, FA);
        t = mk(2'b10, 5'h00, 2, 0, 0); t.payload_dw = 1; tx(t, MI, FA);
        tx(mk(2'b10, 5'h00, 33, 0, 0), MI, FA);
        tx(mk(2'b10, 5'h00, 32, 0, 0), NO, FA);
        t = mk(2'b00, 5'h00, 1, 0, 0); t.td = 1; tx(t, MI, FA);
        tx(mk(2'b00, 5'h00, 1, 1, 0), MI, FA);
        eg(3'h1, TEC_CAUSE_MALF_EG);
        eg(3'h0, NO);
        wr(`TEC_OFS_VC0CTL, 32'hFF);
        tx(mk(2'b00, `TEC_TYP_IO, 2, 0, 0), MI, FA);
        t = mk(2'b00, `TEC_TYP_IO, 1, 0, 0); tx(t, NO, FA); t.attr = 1; tx(t, MI, FA);
        t = mk(2'b00, `TEC_TYP_CFG0, 1, 0, 0); t.last_be = 4'h1; tx(t, MI, FA);
        tx(mk(2'b00, `TEC_TYP_CFG1, 1, 1, 0), MI, FA);
        tx(mk(2'b01, 5'h10, 1, 1, `TEC_MSG_ERR_COR), MI, FA);
        tx(mk(2'b01, 5'h10, 1, 0, `TEC_MSG_ERR_COR), NO, FA);
        tx(mk(2'b01, 5'h15, 1, 0, `TEC_MSG_PME_TO_ACK), NO, FA);
        tx(mk(2'b01, 5'h15, 1, 0, `TEC_MSG_PME_OFF), MI, FA);
        tx(mk(2'b01, 5'h13, 1, 0, `TEC_MSG_PME_OFF), MI, FA);
        tx(mk(2'b01, `TEC_TYP_TCFG, 1, 0, 0), MI, FA);
        tx(mk(2'b01, 5'h14, 1, 0, 8'h20), NO, FA);
        wr(`TEC_OFS_CTRL, 32'h3);
        tx(mk(2'b01, 5'h10, 1, 0, `TEC_MSG_ERR_COR), MI, FA);
        tx(mk(2'b01, 5'h13, 1, 0, `TEC_MSG_PME_OFF), NO, FA);
        tx(mk(2'b01, 5'h14, 1, 0, 8'h20), MI, FA);
        tx(mk(2'b01, 5'h15, 1, 0, `TEC_MSG_PME_TO_ACK), MI, FA);
        tx(mk(2'b01, `TEC_TYP_TCFG, 1, 0, 0), NO, FA);
        $display("test malformed done");
        @(posedge hclk); rx_ovf <= 1'b1;
        @(posedge hclk); rx_ovf <= 1'b0; #1;
        chk_evt(TEC_CAUSE_OVERFLOW, FA, 128'h0);
        ahb(1'b0, `TEC_OFS_LASTEV, 0, rd); `CHK("lastev", {24'h0, TEC_CAUSE_OVERFLOW, 2'b00, FA}, rd)
        ahb(1'b0, `TEC_OFS_DBGSTS, 0, rd); `CHK("rxovf", 32'h1, rd)
        wr(`TEC_OFS_DBGSTS, 32'h1);
        ahb(1'b0, `TEC_OFS_DBGSTS, 0, rd); `CHK("rxovf clr", 32'h0, rd)
        $display("test overflow done");
        repeat (8) begin
            seed = lfsr(seed);
            wr(`TEC_OFS_VC0CTL, {24'h0, seed[7:0]});
            t = mk(2'b10, 5'h00, {5'h0, seed[12:8]} + 10'd1, seed[15:13], 0);
            tx(t, seed[t.tc] ? NO : MI, FA);
        end
        $display("test random done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
